/* File: hdl/aux_pwr_pkg.sv */
package aux_pwr_pkg;

  // apb register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MANUAL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CODES = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h18;

  // control register fields
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_FAULT_EN = 1;
  localparam int CTRL_PRES_DRV = 2;
  localparam int CTRL_APPLY = 3;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

  // limit code {bit1, bit0}; a 1 means the line is left open
  localparam logic [1:0] CODE_600 = 2'h0; // 375 w initial, 600 w sustained
  localparam logic [1:0] CODE_450 = 2'h1; // 225 w initial, 450 w sustained
  localparam logic [1:0] CODE_300 = 2'h2; // 150 w initial, 300 w sustained
  localparam logic [1:0] CODE_150 = 2'h3; // 100 w initial, 150 w sustained
  localparam logic [1:0] CODE_RESET = CODE_150;

  // status register fields
  localparam int STS_PRESENT_LSB = 0;
  localparam int STS_PGOOD_LSB = 8;
  localparam int STS_STANDBY = 16;
  localparam int STS_COUNT_LSB = 20;
  localparam int CNT_W = 4;

  // codes register: applied codes low half, pin levels high half
  localparam int CODES_LEVEL_LSB = 16;

  // interrupt status layout
  localparam int IRQ_FAULT_LSB = 0;
  localparam int IRQ_PRES_CHG = 8;
  localparam int IRQ_APPLIED = 9;
  localparam int IRQ_W = 10;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 10'h000;

endpackage

/* File: hdl/aux_sideband_sync.sv */
`timescale 1ns/10ps
module aux_sideband_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic [WIDTH-1:0] async_in, // raw card lines
  output logic [WIDTH-1:0] sync_out // lines in the clock domain
);

  logic [WIDTH-1:0] meta_q;

  // two stages; first stage is read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

  a_sync_two_stage: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n, 2) |-> sync_out == $past(async_in, 2))
    else $error("synchroniser output is not input delayed by two");

endmodule

/* File: hdl/aux_power_sideband_manager.sv */
`timescale 1ns/10ps
// Functional notes
// - limit code gives initial power: 00=375W, 01=225W, 10=150W, 11=100W.
// - same codes give sustained power: 600W, 450W, 300W, 150W.
// - code lines are only grounded or left open, never driven high.
// - code lines stay constant while the card is operating.
// - code lines are always provided, independent of optional lines.
// - low power-good on a monitored card flags a fault and response.
// - presence line low means card detected and attached.
// - supply may drive the presence line high push-pull.
// - supply may count present cards and pick codes from the count.
// - code changes happen only in standby with rails off.
// - codes are frozen from power-on request until back in standby.
// - one card 600W, two cards 300W, three or four cards 150W.
module aux_power_sideband_manager
  import aux_pwr_pkg::*;
#(
  parameter int N_PORTS = 4
) (
  input wire logic pclk, // system clock, 20 mhz
  input wire logic presetn, // asynchronous reset, active low
  input wire logic [7:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic supply_on_request_n, // power-on request, active low
  input wire logic main_rails_good, // main rails at full voltage
  input wire logic [N_PORTS-1:0] limit_code_bit0, // bit0 pin level
  output logic [N_PORTS-1:0] limit_code_bit0_drive, // bit0 value, always 0
  output logic [N_PORTS-1:0] limit_code_bit0_en, // bit0 grounded when high
  input wire logic [N_PORTS-1:0] limit_code_bit1, // bit1 pin level
  output logic [N_PORTS-1:0] limit_code_bit1_drive, // bit1 value, always 0
  output logic [N_PORTS-1:0] limit_code_bit1_en, // bit1 grounded when high
  input wire logic [N_PORTS-1:0] card_power_good, // card rails good
  input wire logic [N_PORTS-1:0] card_attached_n, // presence, active low
  output logic [N_PORTS-1:0] card_attached_n_drive, // push-pull value
  output logic [N_PORTS-1:0] card_attached_n_en, // push-pull enable
  output logic [N_PORTS-1:0] card_fault, // card fault per connector
  output logic irq // level interrupt
);

  logic [2*N_PORTS-1:0] sync_bus;
  logic [N_PORTS-1:0] attached_n_s;
  logic [N_PORTS-1:0] pgood_s;
  logic [CTRL_W-1:0] ctrl_q;
  logic [2*N_PORTS-1:0] manual_q;
  logic [N_PORTS-1:0] present_q;
  logic [N_PORTS-1:0] present_d;
  logic [N_PORTS-1:0] fault_d;
  logic [2*N_PORTS-1:0] target_code;
  logic [2*N_PORTS-1:0] applied_code;
  logic [1:0] alloc_code;
  logic [CNT_W-1:0] present_cnt;
  logic standby_d;
  logic standby_q;
  logic standby_prev_q;
  logic enter_standby;
  logic load_code;
  logic access;
  logic wr_en;
  logic apply_req;
  logic [IRQ_W-1:0] irq_sts_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [31:0] rd_mux;
  logic rd_hit;

  // every check below runs on the bus clock and is muted in reset
  default clocking main_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // number of asserted bits, for the card count
  function automatic logic [CNT_W-1:0] count_ones(
    input logic [N_PORTS-1:0] v
  );
    logic [CNT_W-1:0] c;
    c = '0;
    for (int i = 0; i < N_PORTS; i++) begin
      c = c + CNT_W'(v[i]);
    end
    return c;
  endfunction

  // share one full-card budget among the detected cards
  function automatic logic [1:0] code_for_count(input logic [CNT_W-1:0] c);
    case (c)
      CNT_W'(1): return CODE_600;
      CNT_W'(2): return CODE_300;
      default: return CODE_150; // none or three and more
    endcase
  endfunction

  // card lines enter the clock domain here
  aux_sideband_sync #(
    .WIDTH(2 * N_PORTS)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in({~card_attached_n, card_power_good}),
    .sync_out(sync_bus)
  );

  // carried inverted so the reset zero reads as no card, not a false plug
  assign attached_n_s = ~sync_bus[2*N_PORTS-1:N_PORTS];
  assign pgood_s = sync_bus[N_PORTS-1:0];

  // standby: request released and main rails down
  assign standby_d = supply_on_request_n & ~main_rails_good;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_q <= 1'b0;
      standby_prev_q <= 1'b0;
    end else begin
      standby_q <= standby_d;
      standby_prev_q <= standby_q;
    end
  end

  assign enter_standby = standby_q & ~standby_prev_q;

  // apb handshake terms; one wait state before every answer
  assign access = psel & penable;
  assign wr_en = access & pready & pwrite;
  assign apply_req = wr_en & (paddr == ADDR_CTRL) & pwdata[CTRL_APPLY];

  // presence is held while we drive the line ourselves, else we see our echo
  assign present_d = card_attached_n_en[0] ? present_q : ~attached_n_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      present_q <= '0;
    end else begin
      present_q <= present_d; // low level means attached
    end
  end

  assign present_cnt = count_ones(present_q);
  assign alloc_code = code_for_count(present_cnt);

  // target code per port, automatic share or software choice
  always_comb begin
    target_code = manual_q;
    if (ctrl_q[CTRL_AUTO]) begin
      target_code = {N_PORTS{alloc_code}};
    end
  end

  // load only while still in standby: both current and registered view agree
  assign load_code = standby_q & standby_d
                     & (enter_standby | apply_req);

  // code pins: enable high grounds the line, enable low leaves it open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_code_bit0_en <= {N_PORTS{~CODE_RESET[0]}};
      limit_code_bit1_en <= {N_PORTS{~CODE_RESET[1]}};
    end else if (load_code) begin
      for (int i = 0; i < N_PORTS; i++) begin
        limit_code_bit0_en[i] <= ~target_code[2*i];
        limit_code_bit1_en[i] <= ~target_code[2*i+1];
      end
    end
  end

  // open-drain only; the high level comes from the card side pull-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_code_bit0_drive <= '0;
      limit_code_bit1_drive <= '0;
    end else begin
      limit_code_bit0_drive <= '0;
      limit_code_bit1_drive <= '0;
    end
  end

  // applied code as read back, same layout as the manual register
  always_comb begin
    applied_code = '0;
    for (int i = 0; i < N_PORTS; i++) begin
      applied_code[2*i] = ~limit_code_bit0_en[i];
      applied_code[2*i+1] = ~limit_code_bit1_en[i];
    end
  end

  // push-pull presence drive, only outside standby (power-on request or main rails up)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_attached_n_drive <= '0;
      card_attached_n_en <= '0;
    end else begin
      card_attached_n_drive <= '1;
      card_attached_n_en <=
        {N_PORTS{ctrl_q[CTRL_PRES_DRV] & ~standby_d}};
    end
  end

  // fault only for a present card with rails on; a missing card reads low
  assign fault_d = {N_PORTS{ctrl_q[CTRL_FAULT_EN] & ~standby_q}}
                   & present_q & ~pgood_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_fault <= '0;
    end else begin
      card_fault <= fault_d;
    end
  end

  // event sources for the sticky status
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_FAULT_LSB +: N_PORTS] = fault_d & ~card_fault;
    irq_set[IRQ_PRES_CHG] = |(present_d ^ present_q);
    irq_set[IRQ_APPLIED] = load_code;
  end

  assign irq_clr = (wr_en && paddr == ADDR_IRQ_CLR) ? pwdata[IRQ_W-1:0] : '0;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_q <= IRQ_RESET;
    end else begin
      irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_sts_q & irq_en_q);
    end
  end

  // software registers; apply bit is a strobe and is not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      manual_q <= {N_PORTS{CODE_RESET}};
      irq_en_q <= IRQ_RESET;
    end else if (wr_en) begin
      case (paddr)
        ADDR_CTRL: ctrl_q <= pwdata[CTRL_W-1:0];
        ADDR_MANUAL: manual_q <= pwdata[2*N_PORTS-1:0];
        ADDR_IRQ_EN: irq_en_q <= pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // read mux; write-only clear reads as zero
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (paddr)
      ADDR_CTRL: rd_mux[CTRL_W-1:0] = ctrl_q;
      ADDR_MANUAL: rd_mux[2*N_PORTS-1:0] = manual_q;
      ADDR_STATUS: begin
        rd_mux[STS_PRESENT_LSB +: N_PORTS] = present_q;
        rd_mux[STS_PGOOD_LSB +: N_PORTS] = pgood_s;
        rd_mux[STS_STANDBY] = standby_q;
        rd_mux[STS_COUNT_LSB +: CNT_W] = present_cnt;
      end
      ADDR_CODES: begin
        rd_mux[2*N_PORTS-1:0] = applied_code;
        for (int i = 0; i < N_PORTS; i++) begin
          rd_mux[CODES_LEVEL_LSB+2*i] = limit_code_bit0[i];
          rd_mux[CODES_LEVEL_LSB+2*i+1] = limit_code_bit1[i];
        end
      end
      ADDR_IRQ_STS: rd_mux[IRQ_W-1:0] = irq_sts_q;
      ADDR_IRQ_CLR: rd_mux = '0;
      ADDR_IRQ_EN: rd_mux[IRQ_W-1:0] = irq_en_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // answer in the second access cycle, all answer signals registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~rd_hit;
    end else begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
  end

  a_code_open_drain: assert property (
    limit_code_bit0_drive == '0 && limit_code_bit1_drive == '0)
    else $error("code line driven to a high level");

  a_code_only_standby: assert property (
    (limit_code_bit0_en != $past(limit_code_bit0_en) ||
     limit_code_bit1_en != $past(limit_code_bit1_en))
    |-> $past(standby_q) && $past(standby_d))
    else $error("limit code changed outside standby");

  a_code_frozen_run: assert property (
    (!supply_on_request_n && main_rails_good) ##1 !standby_q [*3]
    |-> $stable(limit_code_bit0_en) && $stable(limit_code_bit1_en))
    else $error("limit code moved while powered");

  a_share_one_card: assert property (
    load_code && ctrl_q[CTRL_AUTO] && present_cnt == CNT_W'(1)
    |=> limit_code_bit0_en[0] && limit_code_bit1_en[0])
    else $error("single card did not get the full code");

  a_share_three_cards: assert property (
    load_code && ctrl_q[CTRL_AUTO] && present_cnt == CNT_W'(3)
    |=> !limit_code_bit0_en[0] && !limit_code_bit1_en[0])
    else $error("three cards did not get the lowest code");

  a_manual_code: assert property (
    load_code && !ctrl_q[CTRL_AUTO]
    |=> applied_code == $past(manual_q))
    else $error("manual code not applied as written");

  a_presence_low: assert property (
    !card_attached_n_en[0] ##1 !card_attached_n_en[0]
    |-> present_q == ~$past(attached_n_s))
    else $error("presence status not the inverse of the line");

  a_push_pull_high: assert property (
    card_attached_n_en != '0 |-> card_attached_n_drive == '1 && !standby_q[*1])
    else $error("presence line driven low or in standby");

  a_fault_flag: assert property (
    ctrl_q[CTRL_FAULT_EN] && !standby_q && present_q[0] && !pgood_s[0]
    |=> card_fault[0] ##1 irq_sts_q[IRQ_FAULT_LSB] || $past(card_fault[0], 2))
    else $error("card fault not flagged");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == |($past(irq_sts_q) & $past(irq_en_q)))
    else $error("interrupt does not follow enabled status");

  a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pready |=> pready ##1 !pready)
    else $error("apb answer not after one wait state");

endmodule

/* File: test/aux_card_model.sv */
`timescale 1ns/10ps
module aux_card_model #(
  parameter int N = 4,
  parameter int HOLD_CYC = 40 // shortened fault hold, keeps the run short
) (
  input wire logic clk, // system clock
  input wire logic [N-1:0] plug, // card plugged per connector
  input wire logic [N-1:0] rail_bad, // card rail out of limits
  input wire logic [N-1:0] code0_en, // supply grounds bit0
  input wire logic [N-1:0] code1_en, // supply grounds bit1
  input wire logic [N-1:0] pres_drive, // supply push-pull value
  input wire logic [N-1:0] pres_en, // supply push-pull enable
  output logic [N-1:0] code0_pin, // bit0 wire level
  output logic [N-1:0] code1_pin, // bit1 wire level
  output logic [N-1:0] pgood_pin, // power-good wire level
  output logic [N-1:0] pres_pin, // presence wire level
  output logic [N-1:0] sense_rec // presence level recorded by the card
);
  logic [N-1:0] low_q = '0;
  int cnt_q [N] = '{default: 0};
  logic [1:0] assumed_code;
  // a card that ignores the code lines takes the lowest level
  assign assumed_code = 2'h3;
  // open code lines float up to the card pull-up
  assign code0_pin = ~code0_en;
  assign code1_pin = ~code1_en;
  // released while rails are fine, pulled low in a fault
  assign pgood_pin = ~low_q;
  // plugged card holds presence low unless the supply drives it
  assign pres_pin = (pres_en & pres_drive)
                    | (~pres_en & ~plug);
  // low for the minimum time, longer while the rail stays bad
  always_ff @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      if (rail_bad[i] && plug[i]) begin
        low_q[i] <= 1'b1;
        cnt_q[i] <= HOLD_CYC;
      end else if (cnt_q[i] > 0) begin
        cnt_q[i] <= cnt_q[i] - 1;
      end else begin
        low_q[i] <= 1'b0;
      end
    end
  end
  // the card records the presence level it sees
  always_ff @(posedge clk) begin
    sense_rec <= pres_pin;
  end
endmodule

/* File: test/test_aux_power_sideband_manager.sv */
`timescale 1ns/10ps
module test_aux_power_sideband_manager;
  import aux_pwr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, re;
  logic supply_on_request_n, main_rails_good;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [3:0] limit_code_bit0, limit_code_bit0_drive, limit_code_bit0_en;
  logic [3:0] limit_code_bit1, limit_code_bit1_drive, limit_code_bit1_en;
  logic [3:0] card_power_good, card_attached_n, card_attached_n_drive;
  logic [3:0] card_attached_n_en, card_fault, plug, rail_bad, sense;
  logic [7:0] c;
  int n_mismatch, checks_done, k;

  aux_power_sideband_manager #(.N_PORTS(4)) i_dut (.pclk, .presetn,
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .supply_on_request_n, .main_rails_good, .limit_code_bit0,
    .limit_code_bit0_drive, .limit_code_bit0_en, .limit_code_bit1,
    .limit_code_bit1_drive, .limit_code_bit1_en, .card_power_good,
    .card_attached_n, .card_attached_n_drive, .card_attached_n_en,
    .card_fault, .irq);

  aux_card_model #(.N(4)) i_card (.clk(pclk), .plug, .rail_bad,
    .code0_en(limit_code_bit0_en), .code1_en(limit_code_bit1_en),
    .pres_drive(card_attached_n_drive), .pres_en(card_attached_n_en),
    .code0_pin(limit_code_bit0), .code1_pin(limit_code_bit1),
    .pgood_pin(card_power_good), .pres_pin(card_attached_n),
    .sense_rec(sense));

  task final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  // one transfer; starts a cycle after the last so signals change once
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      final_report();
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task power(input logic on);
    @(posedge pclk);
    supply_on_request_n <= ~on;
    main_rails_good <= on;
    repeat (8) @(posedge pclk);
  endtask

  // open line means a one in the code, grounded means a zero
  task chk_codes(input logic [7:0] cv);
    logic [3:0] e0, e1;
    for (int i = 0; i < 4; i++) begin
      e0[i] = ~cv[2*i];
      e1[i] = ~cv[2*i+1];
    end
    @(negedge pclk);
    chk("bit0 ground", {28'h0, e0}, {28'h0, limit_code_bit0_en});
    chk("bit1 ground", {28'h0, e1}, {28'h0, limit_code_bit1_en});
    chk("code drive", 0,
        {limit_code_bit0_drive, limit_code_bit1_drive});
    apb(0, ADDR_CODES, 0);
    chk("codes reg", {8'h0, cv, 8'h0, cv}, rq);
  endtask

  // auto share by present count
  function automatic logic [7:0] exp_auto(input int n);
    return (n == 1) ? 8'h00 : (n == 2) ? 8'haa : 8'hff;
  endfunction

  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    #(50 * 90000);
    n_mismatch++;
    final_report();
  end

  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    supply_on_request_n = 1;
    main_rails_good = 0;
    plug = 0;
    rail_bad = 0;
    void'($urandom(94159));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // reset state, lowest level on every connector, unmapped access
    chk_codes(8'hff);
    chk("lowest level", {30'h0, i_card.assumed_code},
        {30'h0, limit_code_bit1[0], limit_code_bit0[0]});
    apb(0, ADDR_MANUAL, 0);
    chk("manual reset", 32'hff, rq);
    apb(0, 8'h1c, 0);
    chk("unmapped err", 1, {31'h0, re});
    $display("test reset done");
    // manual codes: frozen while on, loaded on standby entry or strobe
    c = 8'hff;
    for (int i = 0; i < 8; i++) begin
      power(1);
      apb(1, ADDR_MANUAL, (i == 0) ? 8'h00 : (i == 1) ? 8'h55 : $urandom);
      apb(1, ADDR_CTRL, 32'h8);
      apb(1, ADDR_CODES, 0);
      repeat (3) @(posedge pclk);
      chk_codes(c);
      apb(0, ADDR_MANUAL, 0);
      c = rq[7:0];
      power(0);
      chk_codes(c);
      c = (i == 2) ? 8'haa : 8'($urandom);
      apb(1, ADDR_MANUAL, {24'h0, c});
      apb(1, ADDR_CTRL, 32'h8);
      repeat (2) @(posedge pclk);
      chk_codes(c);
    end
    $display("test manual done");
    // auto share for zero to four cards
    apb(1, ADDR_CTRL, 32'h1);
    for (int n = 0; n < 5; n++) begin
      k = (n == 0) ? 1 : (n == 4) ? 0 : n + 1;
      power(1);
      plug <= 4'hf >> (4 - k);
      repeat (6) @(posedge pclk);
      apb(0, ADDR_STATUS, 0);
      chk("present", {28'h0, plug}, {28'h0, rq[3:0]});
      chk("count", k, {28'h0, rq[23:20]});
      chk("pgood", 4'hf, {28'h0, rq[11:8]});
      chk("standby", 0, {31'h0, rq[16]});
      power(0);
      chk_codes(exp_auto(k));
    end
    $display("test auto done");
    // push-pull presence drive only outside standby
    power(1);
    apb(1, ADDR_CTRL, 32'h4);
    repeat (3) @(negedge pclk);
    chk("pres en", 4'hf, card_attached_n_en);
    chk("pres drive", 4'hf, card_attached_n_drive);
    chk("sense rec", 4'hf, sense);
    power(0);
    chk("pres off", 0, card_attached_n_en);
    $display("test drive done");
    // fault on two cards, interrupt raised, masked and cleared
    plug <= 4'hf;
    apb(1, ADDR_CTRL, 32'h2);
    power(1);
    apb(1, ADDR_IRQ_EN, 32'h3ff);
    apb(1, ADDR_IRQ_CLR, 32'h3ff);
    repeat (2) @(negedge pclk);
    chk("irq idle", 0, irq);
    @(posedge pclk) rail_bad <= 4'h5;
    @(posedge pclk) rail_bad <= 4'h0;
    k = 0;
    while (card_fault !== 4'h5 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    chk("fault", 4'h5, card_fault);
    if (card_fault !== 4'h5) begin
      final_report();
    end
    repeat (2) @(negedge pclk);
    chk("irq set", 1, irq);
    apb(0, ADDR_IRQ_STS, 0);
    chk("irq sts", 32'h5, rq);
    apb(1, ADDR_IRQ_EN, 0);
    repeat (2) @(negedge pclk);
    chk("irq masked", 0, irq);
    repeat (60) @(posedge pclk);
    chk("fault gone", 0, card_fault);
    apb(1, ADDR_IRQ_CLR, 32'h3ff);
    apb(0, ADDR_IRQ_STS, 0);
    chk("irq clear", 0, rq);
    $display("test fault done");
    final_report();
  end
endmodule
